//--- verilog/jcap_pkg.sv
// ****************************************************************
// Shared constants and types of the CPU access port.
// ****************************************************************
package jcap_pkg;
  // Clock rate and timing figures.
  localparam int CLK_MHZ      = 50;
  localparam int EXIT_LOW_US  = 100;
  localparam int EXIT_LOW_CYC = EXIT_LOW_US * CLK_MHZ;
  localparam int FUSE_LOW_US  = 5;
  localparam int FUSE_LOW_CYC = FUSE_LOW_US * CLK_MHZ;
  // Register widths.
  localparam int IR_W = 8;
  localparam int DR_W = 16;
  // Instruction codes.
  localparam logic [7:0] IR_CTRL_WRITE   = 8'h13;
  localparam logic [7:0] IR_CTRL_CAPTURE = 8'h14;
  localparam logic [7:0] IR_CTRL_RELEASE = 8'h15;
  localparam logic [7:0] IR_DATA_WORD    = 8'h41;
  localparam logic [7:0] IR_SIG_MODE     = 8'h44;
  localparam logic [7:0] IR_SIG_READOUT  = 8'h46;
  localparam logic [7:0] IR_FUSE_PREPARE = 8'h22;
  localparam logic [7:0] IR_FUSE_BLOW    = 8'h24;
  localparam logic [7:0] IR_BYPASS       = 8'hff;
  localparam logic [7:0] IR_CAPTURE_VAL  = 8'h01;
  // Control register fields, reset values, signature polynomial and fuse toggle count.
  localparam int          CTL_TAKEOVER_BIT = 10;
  localparam int          CTL_SYNC_BIT     = 9;
  localparam int          CTL_FETCH_BIT    = 7;
  localparam logic [15:0] CTL_RESET        = 16'h0000;
  localparam logic [15:0] SIG_RESET        = 16'h0000;
  localparam logic [15:0] SIG_POLY         = 16'h0805;
  localparam logic [1:0]  FUSE_TOGGLES     = 2'h2;
  // Two-wire slot numbers.
  localparam logic [1:0] SLOT_TMS = 2'h0;
  localparam logic [1:0] SLOT_TDI = 2'h1;
  localparam logic [1:0] SLOT_TDO = 2'h2;

  typedef enum logic [3:0] {
    TAP_TLR  = 4'hf, TAP_RTI  = 4'hc, TAP_SDR  = 4'h7, TAP_CDR = 4'h6,
    TAP_SHDR = 4'h2, TAP_E1DR = 4'h1, TAP_PDR  = 4'h3, TAP_E2DR = 4'h0,
    TAP_UDR  = 4'h5, TAP_SIR  = 4'h4, TAP_CIR  = 4'he, TAP_SHIR = 4'ha,
    TAP_E1IR = 4'h9, TAP_PIR  = 4'hb, TAP_E2IR = 4'h8, TAP_UIR  = 4'hd
  } jcap_tap_t;

  // Signals towards the CPU.
  typedef struct packed {
    logic        halt;
    logic        clk;
    logic        pc_inc;
    logic        instr_vld;
    logic [15:0] instr;
  } jcap_cpu_t;

  // Signals from the CPU.
  typedef struct packed {
    logic        sync;
    logic        fetch;
    logic [15:0] mem;
  } jcap_cpu_st_t;

  // Levels crossing into the system clock domain.
  typedef struct packed {
    logic test, tck, tms, tdi, sdat, tgl, sel, two, stms, stdi, fuse;
  } jcap_pins_t;
endpackage : jcap_pkg

//--- verilog/jcap_top.sv
`timescale 1ns/10ps
// ****************************************************************
// CPU access port: scan controller, control register, signature.
// ****************************************************************
// What this block does
// - Control-write scan loads control register; old value out; applies at update.
// - Control-capture scan shows current control register on the data output.
// - After release, no debug register affects the CPU until a control-write update clears the release.
// - Signature mode accumulates memory; counter advances every two CPU clocks.
// - Signature readout shifts the accumulated signature out.
// - During readout, capture and update leave the signature untouched.
// - Prepare arms fuse mode; blow after prepare programs the fuse.
// - A programmed fuse refuses all debug access forever.
// - Shared pins take scan functions only while the test pin is high.
// - Test pin low disables both two-wire and four-wire access.
// - Test pin high: reset held inactive, interrupt latched at rise.
// - Data low then clock selects four-wire; 100 us low exits.
// - Data high on first clock selects two-wire, slots start with mode.
// - Two mode toggles with 5 us low phases form the fuse check.
// - A check with data low reads as blown; scan reset clears it.
// - Two-wire mode makes one scan clock in every data-in slot.
// - Two-wire check after reset ends in Exit2-DR; two clocks recover.
// - Host writes takeover value and polls the sync flag.
// - Host clocks the CPU until the fetch flag shows.
// - Fetch state executes the word delivered by the data register.
// - Takeover bit one holds the CPU; zero lets it run.
module jcap_top
  import jcap_pkg::*;
#(
  parameter int EXIT_CYC = EXIT_LOW_CYC,
  parameter bit NEW_FC   = 1'b1
) (
  // System clock and reset.
  input  wire logic         MCLK_I,
  input  wire logic         RESET_I,
  // Test pin, also the two-wire serial clock.
  input  wire logic         TEST_TWO_WIRE_SERIAL_CLOCK_I,
  // Two-wire data pin, shared with reset and interrupt.
  input  wire logic         SBW_DATA_I,
  output logic              SBW_DATA_O,
  output logic              SBW_DATA_OE_O,
  // Four-wire scan pins.
  input  wire logic         TCK_I,
  input  wire logic         TMS_I,
  input  wire logic         TDI_I,
  output logic              TDO_O,
  output logic              TDO_OE_O,
  // System side.
  output logic              PORT_SCAN_SEL_O,
  output logic              INT_RST_N_O,
  output logic              INT_NMI_O,
  input  wire logic         FUSE_BLOWN_I,
  output logic              FUSE_BURN_O,
  output logic              ACCESS_OK_O,
  // CPU side.
  input  wire jcap_cpu_st_t CPU_I,
  output jcap_cpu_t         CPU_O
);

  // ****************************************************************
  // Link clock domain: two-wire entry and slots.
  // ****************************************************************
  logic       allow_ff;
  logic       tdo_ff;
  logic       lk_act_s1_ff, lk_act_s2_ff, lk_tdo_s1_ff, lk_tdo_s2_ff;
  logic       lk_first_ff, lk_sel_ff, lk_two_ff;
  logic [1:0] lk_slot_ff;
  logic       lk_tms_ff, lk_tdi_ff, lk_tgl_ff;

  // Brings the enable and the data output level onto the link clock.
  always_ff @(posedge TEST_TWO_WIRE_SERIAL_CLOCK_I) begin
    lk_act_s1_ff <= allow_ff;
    lk_act_s2_ff <= lk_act_s1_ff;
    lk_tdo_s1_ff <= tdo_ff;
    lk_tdo_s2_ff <= lk_tdo_s1_ff;
  end

  // First clock picks the mode, then slots run mode, data-in, data-out.
  always_ff @(posedge TEST_TWO_WIRE_SERIAL_CLOCK_I) begin
    if (!lk_act_s2_ff) begin
      lk_first_ff <= 1'b1;
      lk_sel_ff   <= 1'b0;
      lk_two_ff   <= 1'b0;
      lk_slot_ff  <= SLOT_TMS;
    end else if (lk_first_ff) begin
      lk_first_ff <= 1'b0;
      lk_sel_ff   <= 1'b1;
      lk_two_ff   <= SBW_DATA_I;
      lk_slot_ff  <= SLOT_TMS;
    end else if (lk_two_ff) begin
      lk_slot_ff  <= (lk_slot_ff == SLOT_TDO) ? SLOT_TMS
                                              : lk_slot_ff + 2'h1;
    end
  end

  // Slot capture; each data-in slot makes one internal scan clock.
  always_ff @(posedge TEST_TWO_WIRE_SERIAL_CLOCK_I) begin
    if (!lk_act_s2_ff) begin
      lk_tms_ff     <= 1'b0;
      lk_tdi_ff     <= 1'b0;
      lk_tgl_ff     <= 1'b0;
      SBW_DATA_OE_O <= 1'b0;
      SBW_DATA_O    <= 1'b0;
    end else begin
      if (lk_sel_ff && lk_two_ff && lk_slot_ff == SLOT_TMS)
        lk_tms_ff <= SBW_DATA_I;
      if (lk_sel_ff && lk_two_ff && lk_slot_ff == SLOT_TDI) begin
        lk_tdi_ff <= SBW_DATA_I;
        lk_tgl_ff <= ~lk_tgl_ff;
      end
      SBW_DATA_OE_O <= lk_sel_ff && lk_two_ff && lk_slot_ff == SLOT_TDI;
      SBW_DATA_O    <= lk_tdo_s2_ff;
    end
  end

  // ****************************************************************
  // System domain: synchronisers, entry, exit and fuse check.
  // ****************************************************************
  jcap_pins_t pin_s1_ff, pin_s2_ff, pin_d_ff, pin_now;
  logic [$clog2(EXIT_CYC+1)-1:0]     low_cnt_ff;
  logic [$clog2(FUSE_LOW_CYC+1)-1:0] fl_cnt_ff;
  logic [1:0] fc_cnt_ff;
  logic       fake_blown_ff, blown_ff, arm_ff, rel_ff;
  logic       test_w, sel_w, two_w, tms_w, tdi_w, tck_pulse, access_w;
  logic       tms_rise, cpu_clock_input_rise, sig_ph_ff, tap_rst_ev;
  jcap_tap_t  tap_ff, nxt_tap;
  logic [IR_W-1:0] ir_ff, ir_sh_ff, ir_eff;
  logic [DR_W-1:0] dr_sh_ff, ctrl_ff, ctrl_view, sig_ff;

  assign pin_now = '{test: TEST_TWO_WIRE_SERIAL_CLOCK_I, tck: TCK_I, tms: TMS_I,
                     tdi: TDI_I, sdat: SBW_DATA_I, tgl: lk_tgl_ff,
                     sel: lk_sel_ff, two: lk_two_ff, stms: lk_tms_ff,
                     stdi: lk_tdi_ff, fuse: FUSE_BLOWN_I};

  // Two flip-flops on every foreign level, then a delayed copy.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_d_ff  <= '0;
    end else begin
      pin_s1_ff <= pin_now;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
    end
  end

  // Selected mode decides where scan clock, mode and data come from.
  assign test_w    = pin_s2_ff.test;
  assign sel_w     = test_w && pin_s2_ff.sel;
  assign two_w     = pin_s2_ff.two;
  assign tms_w     = two_w ? pin_s2_ff.stms : pin_s2_ff.tms;
  assign tdi_w     = two_w ? pin_s2_ff.stdi : pin_s2_ff.tdi;
  assign tck_pulse = sel_w && (two_w ? pin_s2_ff.tgl ^ pin_d_ff.tgl
                             : pin_s2_ff.tck && !pin_d_ff.tck);
  assign tms_rise  = tms_w && !(two_w ? pin_d_ff.stms : pin_d_ff.tms);
  // CPU clock edges count only in idle; CPU_O.clk still follows data-in in every scan state.
  assign cpu_clock_input_rise = tap_ff == TAP_RTI && tdi_w
                     && !(two_w ? pin_d_ff.stdi : pin_d_ff.tdi);
  assign access_w  = sel_w && fc_cnt_ff == FUSE_TOGGLES
                     && !fake_blown_ff && !blown_ff
                     && !pin_s2_ff.fuse;
  assign ir_eff    = access_w ? ir_ff : IR_BYPASS;

  // Long low on the test pin ends the selected mode.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      low_cnt_ff <= '0;
      allow_ff   <= 1'b0;
    end else begin
      if (test_w)
        low_cnt_ff <= '0;
      else if (low_cnt_ff < EXIT_CYC)
        low_cnt_ff <= low_cnt_ff + 1'b1;
      allow_ff <= low_cnt_ff < EXIT_CYC;
    end
  end

  // Fuse check counts two mode toggles with long enough low phases.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || (NEW_FC && tap_rst_ev)) begin
      fl_cnt_ff     <= '0;
      fc_cnt_ff     <= '0;
      fake_blown_ff <= 1'b0;
    end else begin
      if (tms_w)
        fl_cnt_ff <= '0;
      else if (fl_cnt_ff < FUSE_LOW_CYC)
        fl_cnt_ff <= fl_cnt_ff + 1'b1;
      if (sel_w && tms_rise && fl_cnt_ff >= FUSE_LOW_CYC
          && fc_cnt_ff != FUSE_TOGGLES) begin
        fc_cnt_ff <= fc_cnt_ff + 2'h1;
        if (!tdi_w)
          fake_blown_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Scan controller and registers.
  // ****************************************************************
  // Standard sixteen-state next-state map.
  always_comb begin
    unique case (tap_ff)
      TAP_TLR:  nxt_tap = tms_w ? TAP_TLR  : TAP_RTI;
      TAP_RTI:  nxt_tap = tms_w ? TAP_SDR  : TAP_RTI;
      TAP_SDR:  nxt_tap = tms_w ? TAP_SIR  : TAP_CDR;
      TAP_CDR:  nxt_tap = tms_w ? TAP_E1DR : TAP_SHDR;
      TAP_SHDR: nxt_tap = tms_w ? TAP_E1DR : TAP_SHDR;
      TAP_E1DR: nxt_tap = tms_w ? TAP_UDR  : TAP_PDR;
      TAP_PDR:  nxt_tap = tms_w ? TAP_E2DR : TAP_PDR;
      TAP_E2DR: nxt_tap = tms_w ? TAP_UDR  : TAP_SHDR;
      TAP_UDR:  nxt_tap = tms_w ? TAP_SDR  : TAP_RTI;
      TAP_SIR:  nxt_tap = tms_w ? TAP_TLR  : TAP_CIR;
      TAP_CIR:  nxt_tap = tms_w ? TAP_E1IR : TAP_SHIR;
      TAP_SHIR: nxt_tap = tms_w ? TAP_E1IR : TAP_SHIR;
      TAP_E1IR: nxt_tap = tms_w ? TAP_UIR  : TAP_PIR;
      TAP_PIR:  nxt_tap = tms_w ? TAP_E2IR : TAP_PIR;
      TAP_E2IR: nxt_tap = tms_w ? TAP_UIR  : TAP_SHIR;
      TAP_UIR:  nxt_tap = tms_w ? TAP_SDR  : TAP_RTI;
    endcase
  end

  assign tap_rst_ev = tck_pulse && tap_ff != TAP_TLR
                      && nxt_tap == TAP_TLR;

  // State advances on each scan clock; a low test pin forces reset.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || !test_w)
      tap_ff <= TAP_TLR;
    else if (tck_pulse)
      tap_ff <= nxt_tap;
  end

  // Instruction register path.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || tap_ff == TAP_TLR) begin
      ir_sh_ff <= IR_BYPASS;
      ir_ff    <= IR_BYPASS;
    end else if (tck_pulse) begin
      if (tap_ff == TAP_CIR)
        ir_sh_ff <= IR_CAPTURE_VAL;
      else if (tap_ff == TAP_SHIR)
        ir_sh_ff <= {tdi_w, ir_sh_ff[IR_W-1:1]};
      if (nxt_tap == TAP_UIR)
        ir_ff <= ir_sh_ff;
    end
  end

  // Control view carries live CPU status in its read-only bits.
  always_comb begin
    ctrl_view                = ctrl_ff;
    ctrl_view[CTL_SYNC_BIT]  = CPU_I.sync;
    ctrl_view[CTL_FETCH_BIT] = CPU_I.fetch;
  end

  // Data shift register: capture, shift and update per instruction.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      dr_sh_ff <= '0;
      ctrl_ff  <= CTL_RESET;
    end else if (tck_pulse) begin
      if (tap_ff == TAP_CDR && ir_eff != IR_SIG_READOUT) begin
        if (ir_eff == IR_CTRL_WRITE || ir_eff == IR_CTRL_CAPTURE)
          dr_sh_ff <= ctrl_view;
        else
          dr_sh_ff <= '0;
      end else if (tap_ff == TAP_SHDR) begin
        dr_sh_ff <= {tdi_w, dr_sh_ff[DR_W-1:1]};
      end
      if (nxt_tap == TAP_UDR && ir_eff == IR_CTRL_WRITE)
        ctrl_ff <= dr_sh_ff;
    end
  end

  // Release, fuse arming and fuse programming on instruction update.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rel_ff      <= 1'b0;
      arm_ff      <= 1'b0;
      blown_ff    <= 1'b0;
      FUSE_BURN_O <= 1'b0;
    end else begin
      FUSE_BURN_O <= 1'b0;
      if (tck_pulse && nxt_tap == TAP_UIR && access_w) begin
        arm_ff <= ir_sh_ff == IR_FUSE_PREPARE;
        if (ir_sh_ff == IR_CTRL_RELEASE)
          rel_ff <= 1'b1;
        if (ir_sh_ff == IR_FUSE_BLOW && arm_ff) begin
          FUSE_BURN_O <= 1'b1;
          blown_ff    <= 1'b1;
        end
      end
      if (tck_pulse && nxt_tap == TAP_UDR && ir_eff == IR_CTRL_WRITE)
        rel_ff <= 1'b0;
    end
  end

  // Signature: two CPU clocks per address step, shifted out on readout.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sig_ff    <= SIG_RESET;
      sig_ph_ff <= 1'b0;
    end else if (ir_eff == IR_SIG_MODE && !rel_ff) begin
      if (cpu_clock_input_rise) begin
        sig_ph_ff <= ~sig_ph_ff;
        if (sig_ph_ff)
          sig_ff <= ({sig_ff[DR_W-2:0], 1'b0}
                    ^ (sig_ff[DR_W-1] ? SIG_POLY : '0))
                    ^ CPU_I.mem;
      end
    end else if (ir_eff == IR_SIG_READOUT) begin
      sig_ph_ff <= 1'b0;
      if (tck_pulse && tap_ff == TAP_SHDR)
        sig_ff <= {tdi_w, sig_ff[DR_W-1:1]};
    end else begin
      sig_ph_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  // Data output follows the register being shifted.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      tdo_ff   <= 1'b0;
      TDO_O    <= 1'b0;
      TDO_OE_O <= 1'b0;
    end else begin
      if (tap_ff == TAP_SHIR)
        tdo_ff <= ir_sh_ff[0];
      else if (ir_eff == IR_SIG_READOUT)
        tdo_ff <= sig_ff[0];
      else
        tdo_ff <= dr_sh_ff[0];
      TDO_O    <= tdo_ff;
      TDO_OE_O <= sel_w && !two_w
                  && (tap_ff == TAP_SHDR || tap_ff == TAP_SHIR);
    end
  end

  // Pin sharing, held reset and latched interrupt level.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      PORT_SCAN_SEL_O <= 1'b0;
      INT_RST_N_O     <= 1'b0;
      INT_NMI_O       <= 1'b0;
      ACCESS_OK_O     <= 1'b0;
    end else begin
      PORT_SCAN_SEL_O <= test_w;
      INT_RST_N_O     <= test_w || pin_s2_ff.sdat;
      if (!test_w || !pin_d_ff.test)
        INT_NMI_O <= pin_s2_ff.sdat;
      ACCESS_OK_O     <= access_w;
    end
  end

  // CPU controls: takeover, clock, address step and forced words.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      CPU_O <= '0;
    end else begin
      CPU_O.halt   <= ctrl_ff[CTL_TAKEOVER_BIT] && !rel_ff
                      && access_w;
      CPU_O.clk    <= tdi_w && access_w && !rel_ff;
      CPU_O.pc_inc <= ir_eff == IR_SIG_MODE && !rel_ff
                      && cpu_clock_input_rise && sig_ph_ff;
      CPU_O.instr_vld <= 1'b0;
      if (tck_pulse && nxt_tap == TAP_UDR && ir_eff == IR_DATA_WORD
          && CPU_I.fetch && !rel_ff) begin
        CPU_O.instr     <= dr_sh_ff;
        CPU_O.instr_vld <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  logic upd_w, cap_w;
  assign upd_w = tck_pulse && nxt_tap == TAP_UDR;
  assign cap_w = tck_pulse && tap_ff == TAP_CDR;

  // The window ends before a third host clock edge can arrive.
  sequence s_two_clk;
    (cpu_clock_input_rise && ir_eff == IR_SIG_MODE && !rel_ff && !sig_ph_ff)
    ##[1:30] (cpu_clock_input_rise && ir_eff == IR_SIG_MODE && !rel_ff);
  endsequence

  property p_ctrl_upd;
    upd_w && ir_eff == IR_CTRL_WRITE |=> ctrl_ff == $past(dr_sh_ff);
  endproperty
  a_ctrl_upd: assert property (p_ctrl_upd)
    else $error("control update lost");
  property p_ctrl_cap;
    cap_w && ir_eff == IR_CTRL_CAPTURE |=> dr_sh_ff == $past(ctrl_view);
  endproperty
  a_ctrl_cap: assert property (p_ctrl_cap)
    else $error("control capture wrong");
  property p_release;
    rel_ff |=> !CPU_O.halt && !CPU_O.clk;
  endproperty
  a_release: assert property (p_release)
    else $error("released CPU still driven");
  property p_sig_step;
    s_two_clk |=> CPU_O.pc_inc;
  endproperty
  a_sig_step: assert property (p_sig_step)
    else $error("no address step after two clocks");
  property p_readout_keep;
    (cap_w || upd_w) && ir_eff == IR_SIG_READOUT
      |=> sig_ff == $past(sig_ff);
  endproperty
  a_readout_keep: assert property (p_readout_keep)
    else $error("signature changed outside shift");
  property p_blow;
    FUSE_BURN_O |-> $past(arm_ff) ##1 blown_ff;
  endproperty
  a_blow: assert property (p_blow)
    else $error("fuse programmed without prepare");
  property p_lock;
    blown_ff |=> !ACCESS_OK_O [*2];
  endproperty
  a_lock: assert property (p_lock)
    else $error("access after fuse programmed");
  property p_off;
    !test_w |=> tap_ff == TAP_TLR ##1 !TDO_OE_O;
  endproperty
  a_off: assert property (p_off)
    else $error("port active with test pin low");
  property p_rst_hold;
    test_w |=> INT_RST_N_O && PORT_SCAN_SEL_O;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset not held while test pin high");
  property p_exit;
    low_cnt_ff >= EXIT_CYC |=> !allow_ff;
  endproperty
  a_exit: assert property (p_exit)
    else $error("mode kept after long low");
endmodule : jcap_top

//--- verif/jcap_host_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Host model on the four-wire scan pins.
// ****************************************************************
module jcap_host_model (
  // Pins towards the device.
  output logic        test_o,
  output logic        tck_o,
  output logic        tms_o,
  output logic        tdi_o,
  input  wire logic   tdo_i,
  // Word read back, with a strobe.
  output logic [15:0] word_o,
  output logic        done_o
);
  // Pins idle with the test pin low.
  initial begin
    test_o = 1'b0;
    tck_o  = 1'b0;
    tms_o  = 1'b0;
    tdi_o  = 1'b1;
    word_o = 16'h0000;
    done_o = 1'b0;
  end
  // One scan clock; data out is taken just before the rise.
  task automatic tick(input logic ms, input logic di, output logic so);
    tms_o = ms;
    tdi_o = di;
    #200;
    so    = tdo_i;
    tck_o = 1'b1;
    #200;
    tck_o = 1'b0;
  endtask : tick
  // Short test pin pulses; the data pin level at the fifth rise picks the mode.
  task automatic entry(input int n);
    repeat (n) begin
      test_o = 1'b0;
      #16;
      test_o = 1'b1;
      #16;
    end
    #400;
  endtask : entry
  // Six mode-high clocks and one low clock park the controller in idle.
  task automatic reset_tap();
    logic b;
    repeat (6) tick(1'b1, tdi_o, b);
    tick(1'b0, tdi_o, b);
  endtask : reset_tap
  // Two mode rises, each after a low phase longer than the settle time.
  task automatic fuse_check(input logic di);
    tdi_o = di;
    repeat (2) begin
      tms_o = 1'b0;
      #6000;
      tms_o = 1'b1;
      #6000;
    end
    tms_o = 1'b0;
    #1000;
  endtask : fuse_check
  // Full scan from idle back to idle; ir picks the instruction path.
  task automatic shift(input bit ir, input int n, input logic [15:0] d,
                       input bit chk);
    logic        b;
    logic [15:0] q;
    q = 16'h0000;
    tick(1'b1, tdi_o, b);
    if (ir) tick(1'b1, tdi_o, b);
    tick(1'b0, tdi_o, b);
    tick(1'b0, tdi_o, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], b);
      q[i] = b;
    end
    tick(1'b1, tdi_o, b);
    tick(1'b0, tdi_o, b);
    word_o = q;
    done_o = chk;
    #1;
    done_o = 1'b0;
  endtask : shift
  // Pulses on the data-in pin act as CPU clocks.
  task automatic cpu_clocks(input int n);
    repeat (n) begin
      tdi_o = 1'b1;
      #200;
      tdi_o = 1'b0;
      #200;
    end
  endtask : cpu_clocks
  // Test pin held low long enough to leave the scan mode.
  task automatic leave();
    test_o = 1'b0;
    #3000;
  endtask : leave
endmodule : jcap_host_model

//--- verif/testbench.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench of the CPU access port.
// ****************************************************************
module testbench;
  import jcap_pkg::*;
  logic         mclk = 1'b0;
  logic         rst  = 1'b1;
  logic         sdat = 1'b1;
  logic         fuse = 1'b0;
  jcap_cpu_st_t cpu_st = '0;
  jcap_cpu_t    cpu_o;
  logic         test, tck, tms, tdi, tdo, done, burn, access, sel, rst_n, nmi;
  logic         sdo, sdo_oe, tdo_oe;
  logic [15:0]  word;
  logic [15:0]  exp_q[$];
  logic [15:0]  ins_q[$];
  logic [31:0]  lfsr = 32'h7579;
  int           bad_count, checks_done, n_pc, n_burn, n_ins, c;

  // Free-running system clock.
  always #10 mclk = ~mclk;

  jcap_top #(.EXIT_CYC(50)) DUT (
    .MCLK_I(mclk), .RESET_I(rst), .TEST_TWO_WIRE_SERIAL_CLOCK_I(test), .SBW_DATA_I(sdat),
    .SBW_DATA_O(sdo), .SBW_DATA_OE_O(sdo_oe), .TCK_I(tck), .TMS_I(tms),
    .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PORT_SCAN_SEL_O(sel),
    .INT_RST_N_O(rst_n),
    .INT_NMI_O(nmi), .FUSE_BLOWN_I(fuse), .FUSE_BURN_O(burn),
    .ACCESS_OK_O(access), .CPU_I(cpu_st), .CPU_O(cpu_o));

  jcap_host_model host (.test_o(test), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .tdo_i(tdo), .word_o(word), .done_o(done));

  function automatic logic [15:0] step_lfsr();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction : step_lfsr
  // Control word as read back: bits 9 and 7 come from the CPU.
  function automatic logic [15:0] view(input logic [15:0] x);
    return (x & 16'hfd7f) | {6'h00, cpu_st.sync, 1'b0, cpu_st.fetch, 7'h00};
  endfunction : view
  // One signature step over the CPU's current memory word.
  function automatic logic [15:0] sig_next(input logic [15:0] s);
    return ({s[14:0], 1'b0} ^ (s[15] ? SIG_POLY : 16'h0000)) ^ cpu_st.mem;
  endfunction : sig_next
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic lvl(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask : lvl
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : wait_clk
  task automatic ir(input logic [7:0] code);
    host.shift(1'b1, 8, {8'h00, code}, 1'b0);
  endtask : ir
  task automatic dr(input logic [15:0] d, input logic [15:0] e, input bit k);
    if (k) exp_q.push_back(e);
    host.shift(1'b0, 16, d, k);
  endtask : dr
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Scan words are compared with the oldest expectation.
  always @(posedge done) begin
    cmp(word, exp_q.pop_front());
  end
  // Pulse outputs are sampled away from the launching edge.
  always @(negedge mclk) begin
    if (cpu_o.instr_vld === 1'b1) begin
      n_ins++;
      cmp(cpu_o.instr, ins_q.pop_front());
    end
    n_pc += int'(cpu_o.pc_inc === 1'b1);
    n_burn += int'(burn === 1'b1);
  end

  // Main sequence.
  initial begin
    logic [15:0] prev, r;
    wait_clk(4);
    rst = 1'b0;
    wait_clk(60);
    lvl(sel, 1'b0);
    lvl(access, 1'b0);
    lvl(rst_n, 1'b1);
    sdat = 1'b0;
    wait_clk(10);
    lvl(rst_n, 1'b0);
    host.entry(8);
    wait_clk(10);
    lvl(rst_n, 1'b1);
    cmp({14'h0000, sdo_oe, sdo}, 16'h0000);
    sdat = 1'b1;
    wait_clk(10);
    lvl(sel, 1'b1);
    lvl(nmi, 1'b0);
    host.reset_tap();
    host.fuse_check(1'b0);
    wait_clk(10);
    lvl(access, 1'b0);
    host.reset_tap();
    host.fuse_check(1'b1);
    wait_clk(10);
    lvl(access, 1'b1);
    ir(IR_CTRL_WRITE);
    dr(16'h2401, view(CTL_RESET), 1'b1);
    wait_clk(4);
    lvl(cpu_o.halt, 1'b1);
    cpu_st.sync = 1'b1;
    ir(IR_CTRL_CAPTURE);
    dr(16'h0000, 16'h2601, 1'b1);
    ir(IR_CTRL_WRITE);
    prev = 16'h2401;
    for (int i = 0; i < 5; i++) begin
      wait_clk(1);
      r = (i == 4) ? 16'h2401 : step_lfsr();
      cpu_st.fetch = lfsr[7];
      cpu_st.mem = step_lfsr();
      dr(r, view(prev), 1'b1);
      wait_clk(4);
      lvl(cpu_o.halt, r[CTL_TAKEOVER_BIT]);
      prev = r;
    end
    cpu_st.fetch = 1'b1;
    ir(IR_DATA_WORD);
    r = step_lfsr();
    ins_q.push_back(r);
    dr(r, 16'h0000, 1'b0);
    ir(IR_SIG_MODE);
    c = n_pc;
    host.cpu_clocks(8);
    wait_clk(4);
    cmp(16'(n_pc - c), 16'h0004);
    r = SIG_RESET;
    repeat (4) r = sig_next(r);
    ir(IR_SIG_READOUT);
    dr(16'h0000, r, 1'b1);
    ir(IR_CTRL_RELEASE);
    wait_clk(4);
    lvl(cpu_o.halt, 1'b0);
    ir(IR_SIG_MODE);
    c = n_pc;
    host.cpu_clocks(8);
    wait_clk(4);
    cmp(16'(n_pc - c), 16'h0000);
    c = n_burn;
    ir(IR_FUSE_BLOW);
    ir(IR_FUSE_PREPARE);
    ir(IR_FUSE_BLOW);
    wait_clk(4);
    cmp(16'(n_burn - c), 16'h0001);
    fuse = 1'b1;
    host.reset_tap();
    host.fuse_check(1'b1);
    wait_clk(10);
    lvl(access, 1'b0);
    host.leave();
    lvl(sel, 1'b0);
    lvl(tdo_oe, 1'b0);
    host.entry(7);
    wait_clk(10);
    lvl(sdo_oe, 1'b1);
    cmp(16'(n_ins), 16'h0001);
    give_verdict();
  end

  // Watchdog against a hung handshake.
  initial begin
    #1500000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench
